// *** include/tmr_defines.svh ***
// Constants of the 8-bit timer/counter: register map, field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from the package and the design files.
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// ====================================================================
// Register map (byte addresses, one 32-bit word each)
`define TMR_ADDR_W 5
`define TMR_OFF_COUNT 5'h00
`define TMR_OFF_CFG 5'h04
`define TMR_OFF_STATUS 5'h08
`define TMR_OFF_CLEAR 5'h0c
`define TMR_OFF_ENABLE 5'h10

// ====================================================================
// Configuration word fields
`define TMR_CFG_CS_BIT 5
`define TMR_CFG_SE_BIT 4
`define TMR_CFG_PSA_BIT 3
`define TMR_CFG_RATE_HI 2
`define TMR_CFG_RATE_LO 0
`define TMR_CFG_RESET_CS 1'b1
`define TMR_CFG_RESET_SE 1'b1
`define TMR_CFG_RESET_PSA 1'b1
`define TMR_CFG_RESET_RATE 3'h7

// Interrupt status/clear/enable layout
`define TMR_IRQ_OVF_BIT 0

// ====================================================================
// Counter values and timing
`define TMR_COUNT_MAX 8'hff
`define TMR_COUNT_ZERO 8'h00
`define TMR_COUNT_ONE 8'h01
`define TMR_PSC_ZERO 8'h00
`define TMR_PSC_ONE 8'h01
`define TMR_INHIBIT_CYC 2
`define TMR_INHIBIT_LOAD 2'((`TMR_INHIBIT_CYC) + 1)
`define TMR_INHIBIT_NONE 2'h0
`define TMR_INHIBIT_STEP 2'h1
`define TMR_WORD_ZERO 32'h0000_0000

`endif

// *** include/tmr_pkg.sv ***
// Types shared by the timer/counter and its prescaler.
// Assumes tmr_defines.svh is on the include path.
`include "tmr_defines.svh"

package tmr_pkg;

    // Quarter phases of one instruction cycle, Gray coded
    typedef enum logic [1:0] {
        Q1 = 2'h0,
        Q2 = 2'h1,
        Q3 = 2'h3,
        Q4 = 2'h2
    } q_phase_t;

    typedef struct packed {
        logic [7:0] cnt;
    } psc_state_t;

    typedef struct packed {
        q_phase_t q;
        logic [7:0] count;
        logic cs;
        logic se;
        logic prescaler_bypass;
        logic [2:0] rate;
        logic [1:0] inh;
        logic samp;
        logic pin_d;
        logic flag;
        logic ien;
        logic irq;
        logic ovf;
        logic waitreq;
        logic [31:0] rdata;
    } tmr_state_t;

    typedef struct packed {
        logic [`TMR_ADDR_W-1:0] address;
        logic [3:0] byteenable;
        logic read;
        logic write;
        logic [31:0] writedata;
    } avs_req_t;

endpackage

// *** sim/ext_src.sv ***
// Edge source standing on the external count input pin.
// Assumes the bench calls toggle from a process synced to mclk_i.
`timescale 1ns/100ps
`default_nettype none

module ext_src (
    input wire logic mclk_i,
    output logic pin_o
);
    initial begin
        pin_o = 1'b0;
    end

    // Each level held for half clocks, two samples wide at least
    task automatic toggle(input int n, input int half);
        begin
            repeat (n) begin
                pin_o <= ~pin_o;
                repeat (half) @(posedge mclk_i);
            end
        end
    endtask
endmodule

`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench of the timer/counter over its Avalon-MM slave.
// Assumes tmr_defines.svh on the include path and ext_src on the pin.
`timescale 1ns/100ps
`default_nettype none
`include "tmr_defines.svh"

module testbench;
    typedef struct packed {
        logic [31:0] lo;
        logic [31:0] hi;
    } exp_t;
    logic mclk_i, rst_i, rd_i, wr_i, sleep_i, pin, irq, gate, wait_o;
    logic [4:0] addr;
    logic [3:0] be;
    logic [31:0] wdata, rdata;
    int err_total = 0;
    int compares = 0;
    int gates = 0;
    int seed = 23;
    exp_t expq[$];
    exp_t mon_e;

    ext_src src (.mclk_i(mclk_i), .pin_o(pin));

    tmr_counter DUT (
        .mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(addr), .avs_byteenable_i(be),
        .avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wdata),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .external_count_input_i(pin), .sleep_i(sleep_i), .irq_o(irq),
        .overflow_gate_o(gate)
    );

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // ==========================================================
    // Reporting and compare
    task end_sim;
        begin
            if (err_total == 0 && compares > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask

    task automatic chk(input string name, input logic [31:0] lo, hi, seen);
        begin
            compares++;
            if (((seen >= lo) && (seen <= hi)) !== 1'b1) begin
                err_total++;
                $display("ERROR %s expected %h..%h seen %h", name, lo, hi, seen);
            end
        end
    endtask

    always @(posedge mclk_i) begin
        if (gate === 1'b1) gates++;
        if (rd_i === 1'b1 && wait_o === 1'b0) begin
            if (expq.size() == 0) begin
                err_total++;
                $display("ERROR readdata expected none seen %h", rdata);
            end else begin
                mon_e = expq.pop_front();
                chk("readdata", mon_e.lo, mon_e.hi, rdata);
            end
        end
    end

    // ==========================================================
    // Bus cycles
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        int n;
        begin
            addr <= a;
            wdata <= d;
            be <= b;
            rd_i <= ~w;
            wr_i <= w;
            n = 0;
            do begin
                @(posedge mclk_i);
                n++;
            end while (wait_o !== 1'b0 && n < 50);
            if (n >= 50) begin
                err_total++;
                end_sim();
            end
            rd_i <= 1'b0;
            wr_i <= 1'b0;
            @(posedge mclk_i);
        end
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] lo, hi);
        begin
            expq.push_back('{lo, hi});
            bus(1'b0, a, 32'h0000_0000, 4'hf);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    // Awake for exactly k instruction cycles
    task automatic run(input int k);
        begin
            sleep_i <= 1'b0;
            repeat (4 * k) @(posedge mclk_i);
            sleep_i <= 1'b1;
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] e;
        int k;
        int g0;
        rst_i = 1'b1;
        rd_i = 1'b0;
        wr_i = 1'b0;
        addr = 5'h00;
        be = 4'hf;
        wdata = 32'h0000_0000;
        sleep_i = 1'b1;
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        rd(`TMR_OFF_CFG, 32'h3f, 32'h3f);
        rd(`TMR_OFF_COUNT, 32'h0, 32'h0);
        rd(`TMR_OFF_STATUS, 32'h0, 32'h0);
        rd(`TMR_OFF_CLEAR, 32'h0, 32'h0);
        rd(`TMR_OFF_ENABLE, 32'h0, 32'h0);
        wr(5'h14, 32'h0000_00ff);
        rd(5'h14, 32'h0, 32'h0);
        bus(1'b1, `TMR_OFF_CFG, 32'h0000_0000, 4'he);
        rd(`TMR_OFF_CFG, 32'h3f, 32'h3f);
        wr(`TMR_OFF_CFG, 32'h0000_0008);
        for (int i = 0; i < 5; i++) begin
            e = 32'($random(seed)) & 32'hff;
            k = 3 + ($random(seed) & 15);
            wr(`TMR_OFF_COUNT, e);
            run(k);
            e = (e + 32'(k) - 32'h3) & 32'hff;
            rd(`TMR_OFF_COUNT, e, e);
        end
        repeat (40) @(posedge mclk_i);
        rd(`TMR_OFF_COUNT, e, e);
        wr(`TMR_OFF_CLEAR, 32'h0000_0001);
        g0 = gates;
        wr(`TMR_OFF_COUNT, 32'h0000_00fe);
        run(7);
        rd(`TMR_OFF_COUNT, 32'h2, 32'h2);
        rd(`TMR_OFF_STATUS, 32'h1, 32'h1);
        chk("gate", 32'(g0 + 1), 32'(g0 + 1), 32'(gates));
        chk("irq", 32'h0, 32'h0, {31'h0, irq});
        wr(`TMR_OFF_CLEAR, 32'h0000_0000);
        run(3);
        rd(`TMR_OFF_STATUS, 32'h1, 32'h1);
        wr(`TMR_OFF_ENABLE, 32'h0000_0001);
        rd(`TMR_OFF_ENABLE, 32'h1, 32'h1);
        chk("irq", 32'h1, 32'h1, {31'h0, irq});
        wr(`TMR_OFF_CLEAR, 32'h0000_0001);
        rd(`TMR_OFF_STATUS, 32'h0, 32'h0);
        chk("irq", 32'h0, 32'h0, {31'h0, irq});
        for (int r = 0; r < 8; r++) begin
            wr(`TMR_OFF_CFG, 32'(r));
            wr(`TMR_OFF_COUNT, 32'h0000_0000);
            run(4 * (2 << r) + 3);
            rd(`TMR_OFF_COUNT, 32'h3, 32'h5);
        end
        sleep_i <= 1'b0;
        wr(`TMR_OFF_CFG, 32'h0000_0028);
        wr(`TMR_OFF_COUNT, 32'h0000_0000);
        repeat (20) @(posedge mclk_i);
        src.toggle(5, 4);
        repeat (8) @(posedge mclk_i);
        rd(`TMR_OFF_COUNT, 32'h3, 32'h3);
        wr(`TMR_OFF_CFG, 32'h0000_0038);
        wr(`TMR_OFF_COUNT, 32'h0000_0000);
        repeat (20) @(posedge mclk_i);
        src.toggle(3, 4);
        repeat (8) @(posedge mclk_i);
        rd(`TMR_OFF_COUNT, 32'h2, 32'h2);
        wr(`TMR_OFF_CFG, 32'h0000_0020);
        wr(`TMR_OFF_COUNT, 32'h0000_0000);
        repeat (20) @(posedge mclk_i);
        src.toggle(8, 4);
        repeat (8) @(posedge mclk_i);
        rd(`TMR_OFF_COUNT, 32'h2, 32'h2);
        sleep_i <= 1'b1;
        src.toggle(4, 4);
        rd(`TMR_OFF_COUNT, 32'h2, 32'h2);
        end_sim();
    end
endmodule

`default_nettype wire

// *** src/tmr_counter.sv ***
// 8-bit timer/counter with prescaler, overflow flag and Avalon-MM slave.
// Assumes mclk_i is the oscillator clock; four clocks form one
// instruction cycle. All inputs are synchronous to mclk_i.
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "tmr_defines.svh"

module tmr_counter (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [`TMR_ADDR_W-1:0] avs_address_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic external_count_input_i,
    input wire logic sleep_i,
    output logic irq_o,
    output logic overflow_gate_o
);
    localparam tmr_pkg::tmr_state_t RESET_ST = '{
        q: tmr_pkg::Q1,
        count: `TMR_COUNT_ZERO,
        cs: `TMR_CFG_RESET_CS,
        se: `TMR_CFG_RESET_SE,
        prescaler_bypass: `TMR_CFG_RESET_PSA,
        rate: `TMR_CFG_RESET_RATE,
        inh: `TMR_INHIBIT_NONE,
        samp: 1'b1, // No false count right after reset
        pin_d: 1'b0,
        flag: 1'b0,
        ien: 1'b0,
        irq: 1'b0,
        ovf: 1'b0,
        waitreq: 1'b1,
        rdata: `TMR_WORD_ZERO
    };

    tmr_pkg::tmr_state_t st;
    tmr_pkg::tmr_state_t next_st;
    tmr_pkg::avs_req_t req;

    logic [`TMR_ADDR_W-1:0] word_addr;
    logic commit;
    logic wr_cnt;
    logic wr_cfg;
    logic wr_clr;
    logic wr_ena;
    logic pin_lvl;
    logic pin_evt;
    logic psc_tick;
    logic psc_out;
    logic src_lvl;
    logic samp_phase;
    logic use_sample;
    logic inc;

    assign req = '{
        address: avs_address_i,
        byteenable: avs_byteenable_i,
        read: avs_read_i,
        write: avs_write_i,
        writedata: avs_writedata_i
    };

    // ================================================================
    // Bus decode: a write with byteenable bit 0 set takes effect at the edge where waitrequest is low
    assign word_addr = {req.address[`TMR_ADDR_W-1:2], 2'b00};
    assign commit = req.write && !st.waitreq && req.byteenable[0];
    assign wr_cnt = commit && (word_addr == `TMR_OFF_COUNT);
    assign wr_cfg = commit && (word_addr == `TMR_OFF_CFG);
    assign wr_clr = commit && (word_addr == `TMR_OFF_CLEAR);
    assign wr_ena = commit && (word_addr == `TMR_OFF_ENABLE);

    // ================================================================
    // Count source selection
    assign pin_lvl = external_count_input_i ^ st.se;
    assign pin_evt = pin_lvl && !(st.pin_d ^ st.se);
    assign psc_tick = !sleep_i && (st.cs ? pin_evt : (st.q == tmr_pkg::Q4));
    assign src_lvl = st.prescaler_bypass ? (st.cs && pin_lvl) : psc_out;
    assign samp_phase = !sleep_i && (st.q == tmr_pkg::Q2 || st.q == tmr_pkg::Q4);
    assign use_sample = st.cs || !st.prescaler_bypass;
    always_comb begin
        inc = 1'b0;
        if (!sleep_i && st.inh == `TMR_INHIBIT_NONE) begin
            if (use_sample) begin
                inc = samp_phase && src_lvl && !st.samp;
            end else begin
                inc = st.q == tmr_pkg::Q4;
            end
        end
    end

    tmr_prescaler u_prescaler (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .clr_i(wr_cnt),
        .tick_i(psc_tick),
        .rate_i(st.rate),
        .out_o(psc_out)
    );

    // ================================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.pin_d = external_count_input_i;
        next_st.ovf = 1'b0;
        if (!sleep_i) begin
            unique case (st.q)
                tmr_pkg::Q1: next_st.q = tmr_pkg::Q2;
                tmr_pkg::Q2: next_st.q = tmr_pkg::Q3;
                tmr_pkg::Q3: next_st.q = tmr_pkg::Q4;
                tmr_pkg::Q4: next_st.q = tmr_pkg::Q1;
            endcase
        end
        if (samp_phase) begin
            next_st.samp = src_lvl;
        end
        if (!sleep_i && st.q == tmr_pkg::Q4 && st.inh != `TMR_INHIBIT_NONE) begin
            next_st.inh = st.inh - `TMR_INHIBIT_STEP;
        end
        if (inc) begin
            next_st.count = st.count + `TMR_COUNT_ONE;
            if (st.count == `TMR_COUNT_MAX) begin
                next_st.ovf = !wr_cnt;
            end
        end
        if (wr_cnt) begin
            next_st.count = req.writedata[7:0];
            next_st.inh = `TMR_INHIBIT_LOAD;
        end
        if (wr_cfg) begin
            next_st.cs = req.writedata[`TMR_CFG_CS_BIT];
            next_st.se = req.writedata[`TMR_CFG_SE_BIT];
            next_st.prescaler_bypass = req.writedata[`TMR_CFG_PSA_BIT];
            next_st.rate = req.writedata[`TMR_CFG_RATE_HI:`TMR_CFG_RATE_LO];
        end
        if (wr_ena) begin
            next_st.ien = req.writedata[`TMR_IRQ_OVF_BIT];
        end
        // Set wins over a clear in the same cycle
        if (wr_clr && req.writedata[`TMR_IRQ_OVF_BIT]) begin
            next_st.flag = 1'b0;
        end
        if (next_st.ovf) begin
            next_st.flag = 1'b1;
        end
        next_st.irq = next_st.flag && next_st.ien;
        // Bus answer: waitrequest drops one cycle after the request
        next_st.waitreq = !(st.waitreq && (req.read || req.write));
        if (st.waitreq && req.read) begin
            next_st.rdata = `TMR_WORD_ZERO;
            unique case (word_addr)
                `TMR_OFF_COUNT: next_st.rdata[7:0] = st.count;
                `TMR_OFF_CFG: begin
                    next_st.rdata[`TMR_CFG_CS_BIT] = st.cs;
                    next_st.rdata[`TMR_CFG_SE_BIT] = st.se;
                    next_st.rdata[`TMR_CFG_PSA_BIT] = st.prescaler_bypass;
                    next_st.rdata[`TMR_CFG_RATE_HI:`TMR_CFG_RATE_LO] = st.rate;
                end
                `TMR_OFF_STATUS: next_st.rdata[`TMR_IRQ_OVF_BIT] = st.flag;
                `TMR_OFF_ENABLE: next_st.rdata[`TMR_IRQ_OVF_BIT] = st.ien;
                default: next_st.rdata = `TMR_WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= RESET_ST;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata_o = st.rdata;
    assign avs_waitrequest_o = st.waitreq;
    assign irq_o = st.irq;
    assign overflow_gate_o = st.ovf;

    // ================================================================
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_timer_step: assert property (
        st.q == tmr_pkg::Q4 && !st.cs && st.prescaler_bypass && st.inh == `TMR_INHIBIT_NONE
        && !sleep_i && !wr_cnt |=> st.count == $past(st.count) + `TMR_COUNT_ONE)
        else $error("timer did not advance at Q4");
    a_write_pause: assert property (
        wr_cnt ##1 (!wr_cnt)[*8] |-> st.count == $past(req.writedata[7:0], 8))
        else $error("count moved during write pause");
    a_write_load: assert property (
        wr_cnt |=> st.count == $past(req.writedata[7:0]))
        else $error("count write not loaded");
    a_sample_phase: assert property (
        !(st.q == tmr_pkg::Q2 || st.q == tmr_pkg::Q4) |=> $stable(st.samp))
        else $error("source sampled outside Q2 or Q4");
    a_clear_psc: assert property (
        wr_cnt |=> !psc_out) else $error("prescaler not cleared by count write");
    a_wrap_flag: assert property (
        inc && st.count == `TMR_COUNT_MAX && !wr_cnt
        |=> st.flag && st.count == `TMR_COUNT_ZERO && overflow_gate_o)
        else $error("wrap did not set flag");
    a_flag_sticky: assert property (
        st.flag && !wr_clr |=> st.flag) else $error("flag cleared by hardware");
    a_irq_level: assert property (
        irq_o == (st.flag && st.ien)) else $error("irq does not follow flag and enable");
    a_sleep_freeze: assert property (
        sleep_i && !wr_cnt |=> $stable(st.count) && $stable(st.q))
        else $error("counter moved in sleep");
    a_gate_pulse: assert property (
        overflow_gate_o |-> st.flag && st.count == `TMR_COUNT_ZERO)
        else $error("gate pulse without wrap");
    a_bus_answer: assert property (
        (req.read || req.write) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus answer late");

    // ================================================================
    // Counting checks
    a_count_rise: assert property (
        st.cs && st.prescaler_bypass && !st.se && samp_phase && st.inh == `TMR_INHIBIT_NONE
        && !wr_cnt && external_count_input_i && !st.samp
        |=> st.count == $past(st.count) + `TMR_COUNT_ONE)
        else $error("rising pin edge not counted");
    a_count_fall: assert property (
        st.cs && st.prescaler_bypass && st.se && samp_phase && st.inh == `TMR_INHIBIT_NONE
        && !wr_cnt && !external_count_input_i && !st.samp
        |=> st.count == $past(st.count) + `TMR_COUNT_ONE)
        else $error("falling pin edge not counted");
    a_level_hold: assert property (
        use_sample && !(st.q == tmr_pkg::Q2 || st.q == tmr_pkg::Q4) && !wr_cnt
        |=> $stable(st.count)) else $error("count moved outside Q2 or Q4");
    a_psc_route: assert property (
        !st.prescaler_bypass && !psc_out && !wr_cnt |=> $stable(st.count))
        else $error("count moved with prescaler output low");
    a_bypass_rate: assert property (
        !st.cs && st.prescaler_bypass && st.q != tmr_pkg::Q4 && !wr_cnt |=> $stable(st.count))
        else $error("timer moved outside Q4");
    a_cfg_write: assert property (
        wr_cfg |=> st.rate == $past(req.writedata[`TMR_CFG_RATE_HI:`TMR_CFG_RATE_LO])
        && st.prescaler_bypass == $past(req.writedata[`TMR_CFG_PSA_BIT]))
        else $error("rate or bypass not written");
    a_cfg_source: assert property (
        wr_cfg |=> st.cs == $past(req.writedata[`TMR_CFG_CS_BIT])
        && st.se == $past(req.writedata[`TMR_CFG_SE_BIT]))
        else $error("source or edge select not written");
    a_inh_load: assert property (
        wr_cnt |=> st.inh == `TMR_INHIBIT_LOAD) else $error("pause not loaded");
    a_pause_hold: assert property (
        st.inh != `TMR_INHIBIT_NONE && !wr_cnt |=> $stable(st.count))
        else $error("count moved during pause");

    // ================================================================
    // Flag and bus checks
    a_clear_flag: assert property (
        wr_clr && req.writedata[`TMR_IRQ_OVF_BIT] && !(inc && st.count == `TMR_COUNT_MAX)
        |=> !st.flag) else $error("flag clear ignored");
    a_flag_cause: assert property (
        $rose(st.flag) |-> overflow_gate_o) else $error("flag set without wrap");
    a_enable_write: assert property (
        wr_ena |=> st.ien == $past(req.writedata[`TMR_IRQ_OVF_BIT]))
        else $error("enable not written");
    a_irq_quiet: assert property (
        !st.ien |-> !irq_o) else $error("irq raised while disabled");
    a_sleep_gate: assert property (
        sleep_i |=> !overflow_gate_o) else $error("overflow during sleep");
    a_gate_once: assert property (
        overflow_gate_o |=> !overflow_gate_o) else $error("gate pulse too long");
    a_read_count: assert property (
        st.waitreq && avs_read_i && word_addr == `TMR_OFF_COUNT
        |=> avs_readdata_o[7:0] == $past(st.count)) else $error("count read wrong");
    a_read_status: assert property (
        st.waitreq && avs_read_i && word_addr == `TMR_OFF_STATUS
        |=> avs_readdata_o[`TMR_IRQ_OVF_BIT] == $past(st.flag))
        else $error("status read wrong");
    a_wait_idle: assert property (
        !avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer without request");
    a_answer_once: assert property (
        !avs_waitrequest_o |=> avs_waitrequest_o) else $error("answer held too long");

endmodule
`default_nettype wire

// *** src/tmr_prescaler.sv ***
// Eight-stage power-of-two prescaler private to the timer.
// Assumes ticks and clear are synchronous one-cycle strobes on mclk_i.
`timescale 1ns/100ps
`default_nettype none
`include "tmr_defines.svh"

module tmr_prescaler (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic tick_i,
    input wire logic [2:0] rate_i,
    output logic out_o
);
    tmr_pkg::psc_state_t st;
    tmr_pkg::psc_state_t next_st;

    // ================================================================
    // Counter: bit n toggles every 2^n ticks
    always_comb begin
        next_st = st;
        if (clr_i) begin
            next_st.cnt = `TMR_PSC_ZERO;
        end else if (tick_i) begin
            next_st.cnt = st.cnt + `TMR_PSC_ONE;
        end
    end

    assign out_o = st.cnt[rate_i];

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ================================================================
    // Checks
    a_clear_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
        clr_i |=> st.cnt == `TMR_PSC_ZERO) else $error("prescaler not cleared");
    a_tick_step: assert property (@(posedge mclk_i) disable iff (rst_i)
        tick_i && !clr_i |=> st.cnt == $past(st.cnt) + `TMR_PSC_ONE)
        else $error("prescaler missed a tick");
    a_idle_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
        !tick_i && !clr_i |=> $stable(st.cnt)) else $error("prescaler moved idle");

endmodule
`default_nettype wire
